/* rtl/shunt_defs.svh */
// Purpose: Constants of the shunt power measurement engine
// Assumes: 25 MHz system clock, register port with 3-bit word index
// Notes:   Times are kept in microseconds as printed and turned into cycles in the timer
// Function
// - Each voltage conversion lasts one of eight selectable times from 140 us up to 8.244 ms.
// - Shunt time, bus time and averaging count are separate fields of the configuration register at index 0.
// - Results refresh once per set, every sum of the enabled conversion times (shunt, bus or both) times the averaging count.
// - One power count is worth 25 current steps, set by the fixed scaling of the power divide.
// - Current and power come only from the measured voltages and the calibration word.
// - Until a calibration word is written, the current and power results stay at zero.
// - After a calibration word is written, current and power follow each new shunt and bus measurement.
// - Current equals shunt word times calibration word divided by 2048.
// - Power equals current word magnitude times bus word divided by 20000, saturating at 0xFFFF.
// - Shunt, bus, current and power are summed over all samples and the averages loaded only after the last.
// - The bus result weighs 1.25 mV per count whatever the calibration.
`ifndef SHUNT_DEFS_SVH
`define SHUNT_DEFS_SVH

// Register indices
`define REG_CONFIG        3'h0
`define REG_SHUNT         3'h1
`define REG_BUS           3'h2
`define REG_POWER         3'h3
`define REG_CURRENT       3'h4
`define REG_CAL           3'h5

// Reset values and masks
`define CONFIG_RESET      16'h4127
`define CONFIG_FIXED      16'h4000
`define CONFIG_WMASK      16'h0FFF
`define CAL_MASK          16'h7FFF
`define RESULT_RESET      16'h0000
`define BUS_MSB_MASK      16'h7FFF

// Scaling
`define CURRENT_DIV_LOG2  4'hB
`define POWER_DIVISOR     32'h0000_4E20
`define POWER_SAT         32'h0000_FFFF
`define POWER_LSB_RATIO   8'h19
`define BUS_LSB_UV        16'h04E2

// Conversion times in microseconds
`define CT_US_0           14'h008C
`define CT_US_1           14'h00CC
`define CT_US_2           14'h014C
`define CT_US_3           14'h024C
`define CT_US_4           14'h044C
`define CT_US_5           14'h0844
`define CT_US_6           14'h103C
`define CT_US_7           14'h2034

// Averaging counts as powers of two
`define AVG_LOG2_0        4'h0
`define AVG_LOG2_1        4'h2
`define AVG_LOG2_2        4'h4
`define AVG_LOG2_3        4'h6
`define AVG_LOG2_4        4'h7
`define AVG_LOG2_5        4'h8
`define AVG_LOG2_6        4'h9
`define AVG_LOG2_7        4'hA

`endif

/* rtl/shunt_pkg.sv */
// Purpose: Types and lookups of the shunt power measurement engine
// Assumes: shunt_defs.svh holds every number
// Notes:   Configuration layout mirrors the register bit order
`include "shunt_defs.svh"
package shunt_pkg;

    typedef struct packed {
        logic       soft_reset;
        logic [2:0] fixed;
        logic [2:0] avg_sel;
        logic [2:0] bus_ct;
        logic [2:0] shunt_ct;
        logic [2:0] mode;
    } config_t;

    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] current;
        logic [15:0] power;
    } result_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHUNT = 2'b01,
        ST_BUS   = 2'b10,
        ST_LOAD  = 2'b11
    } phase_t;

    // Conversion time of a setting, in microseconds
    function automatic logic [13:0] ct_us(input logic [2:0] sel);
        case (sel)
            3'h0:    ct_us = `CT_US_0;
            3'h1:    ct_us = `CT_US_1;
            3'h2:    ct_us = `CT_US_2;
            3'h3:    ct_us = `CT_US_3;
            3'h4:    ct_us = `CT_US_4;
            3'h5:    ct_us = `CT_US_5;
            3'h6:    ct_us = `CT_US_6;
            default: ct_us = `CT_US_7;
        endcase
    endfunction : ct_us

    // Averaging count as a shift
    function automatic logic [3:0] avg_log2(input logic [2:0] sel);
        case (sel)
            3'h0:    avg_log2 = `AVG_LOG2_0;
            3'h1:    avg_log2 = `AVG_LOG2_1;
            3'h2:    avg_log2 = `AVG_LOG2_2;
            3'h3:    avg_log2 = `AVG_LOG2_3;
            3'h4:    avg_log2 = `AVG_LOG2_4;
            3'h5:    avg_log2 = `AVG_LOG2_5;
            3'h6:    avg_log2 = `AVG_LOG2_6;
            default: avg_log2 = `AVG_LOG2_7;
        endcase
    endfunction : avg_log2

endpackage : shunt_pkg

/* rtl/conversion_timer.sv */
// Purpose: Times one voltage conversion
// Assumes: start is a one-cycle pulse; a new start restarts the count
// Notes:   CYCLES_PER_US may be lowered in simulation to shorten every conversion
`timescale 1ns/1ns
`include "shunt_defs.svh"
module conversion_timer #(
    parameter int CYCLES_PER_US = 25,
    parameter int CNT_W         = 18
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] ct_sel,
    output logic            done
);
    if (CYCLES_PER_US < 1 || (`CT_US_7 * CYCLES_PER_US) >= (2 ** CNT_W)) begin : g_check
        $error("conversion_timer: counter too narrow for the longest conversion");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic             busy_reg;
    wire  [CNT_W-1:0] conversion_period = CNT_W'(shunt_pkg::ct_us(ct_sel) * CYCLES_PER_US);
    wire              last = busy_reg && (cnt_reg == CNT_W'(1));

    // Count down the conversion period, pulse at its end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= last && !start;
            if (start) begin
                cnt_reg  <= conversion_period;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg  <= cnt_reg - CNT_W'(1);
                busy_reg <= !last;
            end
        end
    end

    // Shortest period is 140 cycles even at one cycle per microsecond
    property p_min_period;
        @(posedge clk) disable iff (rst) start |=> !done [*8];
    endproperty
    a_min_period: assert property (p_min_period) else $error("conversion ended too early");

endmodule : conversion_timer

/* rtl/shunt_power_measurement_engine.sv */
// Purpose: Sequences conversions, averages them and scales current and power
// Assumes: Samples arrive synchronous to clk and are valid when a conversion ends
// Notes:   Register port is the device side of the serial register access; reads are one cycle late
`timescale 1ns/1ns
`include "shunt_defs.svh"
module shunt_power_measurement_engine #(
    parameter int CYCLES_PER_US = 25,
    parameter int AVG_MAX_LOG2  = 10
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic [15:0] shunt_sample,
    input  wire logic [15:0] bus_sample,
    output logic      [15:0] rdata,
    output logic             conv_ready
);
    localparam int ACC_W = 17 + AVG_MAX_LOG2;
    if (AVG_MAX_LOG2 < 10 || AVG_MAX_LOG2 > 15) begin : g_check
        $error("shunt_power_measurement_engine: accumulator cannot hold 1024 samples");
    end

    shunt_pkg::config_t cfg_reg;
    shunt_pkg::result_t res_reg;
    shunt_pkg::phase_t  state_reg;
    shunt_pkg::phase_t  state_next;
    logic [15:0]        cal_reg;
    logic               cal_written_reg;
    logic [15:0]        cur_last_reg;
    logic [9:0]         sample_cnt_reg;
    logic signed [ACC_W-1:0] acc_shunt_reg;
    logic signed [ACC_W-1:0] acc_bus_reg;
    logic signed [ACC_W-1:0] acc_cur_reg;
    logic signed [ACC_W-1:0] acc_pwr_reg;
    logic               timer_start;
    logic               timer_done;

    // Average of an accumulator by shift; every count is a power of two
    function automatic logic [15:0] avg16(input logic signed [ACC_W-1:0] a, input logic [3:0] sh);
        avg16 = 16'(a >>> sh);
    endfunction : avg16

    // Register write decode and mode decode
    wire        cfg_wr     = reg_wr && (reg_addr == `REG_CONFIG);
    wire        cal_wr     = reg_wr && (reg_addr == `REG_CAL);
    wire [2:0]  mode       = cfg_reg.mode;
    wire        run_shunt  = mode[0];
    wire        run_bus    = mode[1];
    wire        continuous = mode[2];
    wire        wr_active  = (reg_wdata[1:0] != 2'b00);
    wire [3:0]  avg_sh     = shunt_pkg::avg_log2(cfg_reg.avg_sel);
    wire [9:0]  last_cnt   = 10'((11'h001 << avg_sh) - 11'h001);
    wire        last_smp   = (sample_cnt_reg == last_cnt);
    // A write starts its set with the new times; cfg_reg only catches up at that edge
    wire shunt_pkg::config_t cfg_in  = (reg_wdata & `CONFIG_WMASK) | `CONFIG_FIXED;
    wire shunt_pkg::config_t cfg_src = cfg_wr ? cfg_in : cfg_reg;
    wire [2:0]  ct_sel     = (state_next == shunt_pkg::ST_SHUNT) ? cfg_src.shunt_ct : cfg_src.bus_ct;
    wire shunt_pkg::phase_t first_phase = run_shunt ? shunt_pkg::ST_SHUNT : shunt_pkg::ST_BUS;

    // Scaling: current from shunt and calibration, power from current and bus
    wire [15:0]        bus_clean = bus_sample & `BUS_MSB_MASK;
    wire signed [31:0] prod_cur  = $signed(shunt_sample) * $signed({1'b0, cal_reg[14:0]});
    wire [15:0]        cur_calc  = cal_written_reg ? 16'(prod_cur >>> `CURRENT_DIV_LOG2) : `RESULT_RESET;
    wire [15:0]        cur_abs   = cur_last_reg[15] ? 16'(-cur_last_reg) : cur_last_reg;
    wire [31:0]        prod_pwr  = {16'h0000, cur_abs} * {16'h0000, bus_clean};
    wire [31:0]        quot_pwr  = prod_pwr / `POWER_DIVISOR;
    wire [15:0]        pwr_sat   = (quot_pwr > `POWER_SAT) ? 16'hFFFF : quot_pwr[15:0];
    wire [15:0]        pwr_calc  = cal_written_reg ? pwr_sat : `RESULT_RESET;

    // Readback selection
    wire [15:0] read_mux = (reg_addr == `REG_CONFIG)  ? cfg_reg :
                           (reg_addr == `REG_SHUNT)   ? res_reg.shunt :
                           (reg_addr == `REG_BUS)     ? res_reg.bus :
                           (reg_addr == `REG_POWER)   ? res_reg.power :
                           (reg_addr == `REG_CURRENT) ? res_reg.current :
                           (reg_addr == `REG_CAL)     ? cal_reg : 16'h0000;

    wire phase_done = timer_done && ((state_reg == shunt_pkg::ST_SHUNT) || (state_reg == shunt_pkg::ST_BUS));
    wire load_go    = (state_reg == shunt_pkg::ST_LOAD);

    // Sequencer: shunt then bus per sample, load after the last sample
    always_comb begin
        state_next  = state_reg;
        timer_start = 1'b0;
        case (state_reg)
            shunt_pkg::ST_IDLE:  state_next = shunt_pkg::ST_IDLE;
            shunt_pkg::ST_SHUNT: begin
                if (timer_done) begin
                    if (run_bus) begin
                        state_next = shunt_pkg::ST_BUS;
                    end else if (last_smp) begin
                        state_next = shunt_pkg::ST_LOAD;
                    end
                    timer_start = run_bus || !last_smp;
                end
            end
            shunt_pkg::ST_BUS: begin
                if (timer_done) begin
                    state_next  = last_smp ? shunt_pkg::ST_LOAD : first_phase;
                    timer_start = !last_smp;
                end
            end
            shunt_pkg::ST_LOAD: begin
                state_next  = continuous ? first_phase : shunt_pkg::ST_IDLE;
                timer_start = continuous;
            end
            default: state_next = shunt_pkg::ST_IDLE;
        endcase
        // A configuration write aborts the set and starts over, or goes idle when mode bits 1:0 are both clear
        if (cfg_wr) begin
            state_next  = wr_active ? (reg_wdata[0] ? shunt_pkg::ST_SHUNT : shunt_pkg::ST_BUS)
                                    : shunt_pkg::ST_IDLE;
            timer_start = wr_active;
        end
    end

    conversion_timer #(
        .CYCLES_PER_US (CYCLES_PER_US)
    ) u_timer (
        .clk    (clk),
        .rst    (rst),
        .start  (timer_start),
        .ct_sel (ct_sel),
        .done   (timer_done)
    );

    // Configuration, calibration and readback registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg         <= `CONFIG_RESET;
            cal_reg         <= `RESULT_RESET;
            cal_written_reg <= 1'b0;
            rdata           <= `RESULT_RESET;
        end else begin
            rdata <= read_mux;
            if (cfg_wr) begin
                cfg_reg <= cfg_in;
            end
            if (cal_wr) begin
                cal_reg         <= reg_wdata & `CAL_MASK;
                cal_written_reg <= 1'b1;
            end
        end
    end

    // Sequencer state, sample count and ready flag; setting beats clearing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg      <= shunt_pkg::ST_IDLE;
            sample_cnt_reg <= '0;
            conv_ready     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            conv_ready <= load_go || (conv_ready && !cfg_wr);
            if (cfg_wr || load_go) begin
                sample_cnt_reg <= '0;
            end else if ((state_reg == shunt_pkg::ST_BUS && timer_done) ||
                         (state_reg == shunt_pkg::ST_SHUNT && timer_done && !run_bus)) begin
                sample_cnt_reg <= sample_cnt_reg + 10'h001;
            end
        end
    end

    // Accumulation over the averaged samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_last_reg  <= `RESULT_RESET;
            acc_shunt_reg <= '0;
            acc_cur_reg   <= '0;
            acc_bus_reg   <= '0;
            acc_pwr_reg   <= '0;
        end else if (cfg_wr || load_go) begin
            acc_shunt_reg <= '0;
            acc_cur_reg   <= '0;
            acc_bus_reg   <= '0;
            acc_pwr_reg   <= '0;
        end else if (phase_done && state_reg == shunt_pkg::ST_SHUNT) begin
            cur_last_reg  <= cur_calc;
            acc_shunt_reg <= acc_shunt_reg + ACC_W'($signed(shunt_sample));
            acc_cur_reg   <= acc_cur_reg + ACC_W'($signed(cur_calc));
        end else if (phase_done) begin
            acc_bus_reg   <= acc_bus_reg + ACC_W'({1'b0, bus_clean});
            acc_pwr_reg   <= acc_pwr_reg + ACC_W'({1'b0, pwr_calc});
        end
    end

    // Output results change only after the last sample of a set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_reg <= '0;
        end else if (load_go) begin
            if (run_shunt) begin
                res_reg.shunt   <= avg16(acc_shunt_reg, avg_sh);
                res_reg.current <= avg16(acc_cur_reg, avg_sh);
            end
            if (run_bus) begin
                res_reg.bus     <= avg16(acc_bus_reg, avg_sh);
                res_reg.power   <= avg16(acc_pwr_reg, avg_sh);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_shunt_end;
        state_reg == shunt_pkg::ST_SHUNT && timer_done && run_bus && !cfg_wr;
    endsequence
    sequence s_bus_start;
        state_reg == shunt_pkg::ST_BUS;
    endsequence

    property p_no_cal_zero;
        !cal_written_reg |-> (res_reg.current == 16'h0000) && (res_reg.power == 16'h0000);
    endproperty
    a_no_cal_zero: assert property (p_no_cal_zero) else $error("result nonzero without calibration");

    property p_shunt_then_bus;
        s_shunt_end |=> s_bus_start;
    endproperty
    a_shunt_then_bus: assert property (p_shunt_then_bus) else $error("bus did not follow shunt");

    property p_load_only;
        $changed(res_reg) |-> $past(load_go);
    endproperty
    a_load_only: assert property (p_load_only) else $error("result changed outside a load");

    property p_load_last;
        (phase_done && state_next == shunt_pkg::ST_LOAD && !cfg_wr) |-> last_smp;
    endproperty
    a_load_last: assert property (p_load_last) else $error("load before the last sample");

    property p_bus_msb;
        res_reg.bus[15] == 1'b0;
    endproperty
    a_bus_msb: assert property (p_bus_msb) else $error("bus result MSB set");

    property p_cfg_store;
        cfg_wr |=> cfg_reg.avg_sel == $past(reg_wdata[11:9]) && cfg_reg.shunt_ct == $past(reg_wdata[5:3]);
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("configuration fields not stored");

    property p_current_scale;
        (phase_done && state_reg == shunt_pkg::ST_SHUNT && cal_written_reg && !cfg_wr)
            |=> $signed(cur_last_reg) == 16'($signed($past(shunt_sample)) * $signed($past({1'b0, cal_reg[14:0]})) / 2048
                - (($signed($past(shunt_sample)) < 0) && (16'($past(prod_cur) % 2048) != 0) ? 1 : 0));
    endproperty
    a_current_scale: assert property (p_current_scale) else $error("current word misscaled");

    property p_power_scale;
        (cal_written_reg && prod_pwr < 32'd1310700000) |-> pwr_calc == 16'(prod_pwr / 20000);
    endproperty
    a_power_scale: assert property (p_power_scale) else $error("power word misscaled");

    property p_ready_set;
        load_go |=> conv_ready;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set after load");

endmodule : shunt_power_measurement_engine

/* tb/serial_host_model.sv */
// Purpose: Host controller model on the register side of the engine
// Assumes: One clock; every request launched 1 ns after a rising edge
// Notes:   Serial framing abstracted to whole 16-bit register accesses
`timescale 1ns/1ns
module serial_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output logic      [2:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr
);
    // Idle bus at time zero
    initial begin
        reg_addr  = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
    end

    // Strobe held across exactly one sampling edge
    task automatic write_reg(input logic [2:0] addr, input logic [15:0] data);
        @(posedge clk);
        #1;
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~data; // Stale data inverted, never mistaken for a hold
    endtask : write_reg

    // Address held one edge, data taken after the next
    task automatic read_reg(input logic [2:0] addr, output logic [15:0] data);
        @(posedge clk);
        #1;
        reg_addr = addr;
        @(posedge clk);
        #1;
        data = rdata;
    endtask : read_reg

    // Current step in uA, rounded up to whole mA for simpler scaling
    function automatic longint step_ua(input longint max_ua);
        longint s;
        s = (max_ua + 32767) / 32768;
        step_ua = ((s + 999) / 1000) * 1000;
    endfunction : step_ua

    // Calibration from step (uA) and shunt (micro-ohm); constant scaled by 1e12
    function automatic logic [15:0] cal_word(input longint lsb_ua, input longint r_uohm);
        cal_word = 16'(64'd5120000000 / (lsb_ua * r_uohm));
    endfunction : cal_word
endmodule : serial_host_model

/* tb/shunt_power_measurement_engine_test.sv */
// Purpose: Self-checking bench of the measurement engine
// Assumes: Samples held steady across a set, so averages equal the sample
// Notes:   CYCLES_PER_US is 1 so the longest conversion stays short
`timescale 1ns/1ns
`include "shunt_defs.svh"
module shunt_power_measurement_engine_test;
    localparam int CPU = 1;
    logic        clk;
    logic        rst;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic [15:0] shunt_sample;
    logic [15:0] bus_sample;
    logic [15:0] rdata;
    logic        conv_ready;
    logic [15:0] got;
    logic [15:0] cal_val;
    logic [15:0] cur;
    bit          have_cal;
    int          n_fail;
    int          n_tests;
    int          cyc;
    int          ct_tab[8]  = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
    int          avg_tab[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};

    shunt_power_measurement_engine #(.CYCLES_PER_US(CPU), .AVG_MAX_LOG2(10)) shunt_power_measurement_engine_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .shunt_sample(shunt_sample), .bus_sample(bus_sample), .rdata(rdata), .conv_ready(conv_ready));
    serial_host_model serial_host_model_i (
        .clk(clk), .rdata(rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_reg(input string what, input logic [2:0] addr, input logic [15:0] exp);
        serial_host_model_i.read_reg(addr, got);
        check(what, exp, got);
    endtask : check_reg

    function automatic logic [15:0] make_cfg(input logic [2:0] avg, bct, sct, mode);
        shunt_pkg::config_t c;
        c          = '0;
        c.avg_sel  = avg;
        c.bus_ct   = bct;
        c.shunt_ct = sct;
        c.mode     = mode;
        make_cfg   = c;
    endfunction : make_cfg

    // Signed product floored; zero while uncalibrated
    function automatic logic [15:0] exp_cur(input logic [15:0] s);
        longint p;
        p = longint'(signed'(s)) * longint'(cal_val);
        exp_cur = have_cal ? 16'(p >>> 11) : 16'h0000;
    endfunction : exp_cur

    // Magnitude of current times bus, truncated and saturated
    function automatic logic [15:0] exp_pow(input logic [15:0] cu, input logic [15:0] b);
        longint a;
        a = longint'(signed'(cu));
        if (a < 0) begin
            a = -a;
        end
        a = a * longint'(b) / 20000;
        exp_pow = !have_cal ? 16'h0000 : (a > 65535) ? 16'hFFFF : 16'(a);
    endfunction : exp_pow

    // One set in the given mode; interval counts only the enabled channels
    task automatic run_set(input logic [2:0] avg, bct, sct, md, input bit peek, input logic [15:0] old_sh);
        int lo;
        int hi;
        lo = avg_tab[avg] * ((md[0] ? ct_tab[sct] : 0) + (md[1] ? ct_tab[bct] : 0)) * CPU;
        hi = lo + avg_tab[avg] * 4 + 4;
        serial_host_model_i.write_reg(`REG_CONFIG, make_cfg(avg, bct, sct, md));
        check("ready_clear", 16'h0000, {15'h0000, conv_ready});
        cyc = 0;
        if (peek) begin
            repeat (lo / 2) @(posedge clk);
            check_reg("shunt_mid_set", `REG_SHUNT, old_sh);
            cyc = lo / 2 + 2;
        end
        while (conv_ready !== 1'b1) begin
            @(posedge clk);
            #1;
            cyc++;
            if (cyc > hi) begin
                n_fail++;
                $display("MISMATCH set_timeout expected %0d seen %0d", hi, cyc);
                give_verdict();
            end
        end
        n_tests++;
        if (cyc < lo) begin
            n_fail++;
            $display("MISMATCH set_interval expected %0d seen %0d", lo, cyc);
        end
        cur = exp_cur(shunt_sample);
        check_reg("shunt", `REG_SHUNT, shunt_sample);
        check_reg("bus", `REG_BUS, bus_sample & `BUS_MSB_MASK);
        check_reg("current", `REG_CURRENT, cur);
        check_reg("power", `REG_POWER, exp_pow(cur, bus_sample & `BUS_MSB_MASK));
    endtask : run_set

    // Main sequence
    initial begin
        rst          = 1'b1;
        shunt_sample = 16'h1F40;
        bus_sample   = 16'h2570;
        have_cal     = 1'b0;
        cal_val      = 16'h0000;
        n_fail       = 0;
        n_tests      = 0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        check_reg("config_reset", `REG_CONFIG, `CONFIG_RESET);
        for (int a = 1; a < 8; a++) begin
            check_reg("reg_reset", 3'(a), `RESULT_RESET);
        end
        // All ones, then each field alone; mode writes start sets that later writes abort
        for (int f = 4; f >= 0; f--) begin
            got = (f == 4) ? 16'hFFFF : 16'h0007 << (3 * f);
            serial_host_model_i.write_reg(`REG_CONFIG, got);
            check_reg("config_field", `REG_CONFIG, (got & `CONFIG_WMASK) | `CONFIG_FIXED);
        end
        serial_host_model_i.write_reg(`REG_SHUNT, 16'hAAAA);
        serial_host_model_i.write_reg(3'h6, 16'h5555);
        check_reg("shunt_read_only", `REG_SHUNT, `RESULT_RESET);
        check_reg("unmapped", 3'h6, 16'h0000);
        run_set(3'h0, 3'h0, 3'h0, 3'h3, 1'b0, 16'h0000);
        serial_host_model_i.write_reg(`REG_CAL, 16'hFFFF);
        check_reg("cal_mask", `REG_CAL, `CAL_MASK);
        cal_val  = serial_host_model_i.cal_word(serial_host_model_i.step_ua(64'd15000000), 64'd2000);
        have_cal = 1'b1;
        serial_host_model_i.write_reg(`REG_CAL, cal_val);
        check_reg("cal", `REG_CAL, cal_val & `CAL_MASK);
        run_set(3'h0, 3'h0, 3'h0, 3'h3, 1'b0, 16'h1F40);
        shunt_sample = 16'h0FA0;
        run_set(3'h1, 3'h0, 3'h3, 3'h3, 1'b1, 16'h1F40);
        shunt_sample = 16'hE0C0;
        bus_sample   = 16'hFFFF;
        run_set(3'h0, 3'h3, 3'h6, 3'h3, 1'b0, 16'h0FA0);
        // Shunt only: a bus conversion would overrun the bound; bus and power keep their values
        run_set(3'h0, 3'h0, 3'h7, 3'h1, 1'b0, 16'hE0C0);
        // Continuous: first set of the run, reloads keep identical results
        run_set(3'h0, 3'h0, 3'h0, 3'h7, 1'b0, 16'hE0C0);
        give_verdict();
    end
endmodule : shunt_power_measurement_engine_test
